// [src/emb_pkg.sv]
// shared constants and carriers for the external memory bus interface
// Operation
// - program strobe pulses each slot on external fetch
// - program strobe stays high for internal execution
// - strobe pulled low at reset enters download
// - address strobe latches low and page byte
// - address strobe every six periods, skipped on data
// - select high: 0000h-1fffh fetched internally
// - select low: every fetch goes external
// - low port open drain, ones float
// - low port multiplexes address then data
// - bus ones driven strongly high
// - lowest 32 bytes: four banks, eight registers
// - next 16 bytes bit addressable, 00h-7fh
// - upper 128 special space direct or bit access only
// - program and data spaces kept separate
// - 640 byte data flash via control registers
// - upper port gives high, middle, page bytes
// - write strobe makes memory take data
// - read strobe enables memory onto port
package emb_pkg;
   localparam int SLOT_PERIODS = 6;
   localparam logic [2:0] PH_LAST = 3'h5;
   localparam logic [2:0] PH_ALE_END = 3'h1;
   localparam logic [2:0] PH_STROBE = 3'h3;
   localparam logic [2:0] PH_WR_FIRST = 3'h1;
   localparam logic [2:0] PH_WR_LAST = 3'h4;
   localparam logic [15:0] INT_PROG_TOP = 16'h1fff;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   localparam logic [7:0] RAM_BIT_BASE = 8'h20;
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam int RAM_BYTES = 256;
   localparam int FLASH_BYTES = 640;
   localparam logic [9:0] FLASH_LAST = 10'h27f;
   localparam logic [7:0] FL_ADDR_LO = 8'hb9;
   localparam logic [7:0] FL_ADDR_HI = 8'hba;
   localparam logic [7:0] FL_DATA = 8'hbb;
   localparam logic [7:0] FL_CMD = 8'hbc;
   localparam logic [7:0] FL_CMD_READ = 8'h01;
   localparam logic [7:0] FL_CMD_WRITE = 8'h02;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_XADDR = 2'b10,
      ST_XSTROBE = 2'b11
   } emb_state_t;

   typedef enum logic [1:0] {
      AM_DIRECT = 2'b00,
      AM_INDIRECT = 2'b01,
      AM_REGNUM = 2'b10,
      AM_BIT = 2'b11
   } emb_amode_t;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } emb_fetch_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [23:0] addr;
      logic [7:0] wdata;
   } emb_xdata_t;

   typedef struct packed {
      logic valid;
      logic write;
      emb_amode_t mode;
      logic [7:0] addr;
      logic [7:0] wdata;
   } emb_idata_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } emb_sfr_t;
endpackage : emb_pkg

// [src/emb_idata_space.sv]
// internal data space: banks, bit area, indirect ram, special space, data flash
`timescale 1ns/100ps
module emb_idata_space (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input emb_pkg::emb_idata_t i_req,
   input wire logic [1:0] i_bank,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output emb_pkg::emb_sfr_t o_sfr,
   input wire logic [7:0] i_sfr_rdata
);
   import emb_pkg::*;

   logic [7:0] ram [RAM_BYTES];
   logic [7:0] flash [FLASH_BYTES];
   logic [9:0] fl_addr_r;
   logic [7:0] fl_data_r;
   logic [7:0] rdata_r;
   logic rvalid_r;

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   wire is_bit = (i_req.mode == AM_BIT);
   wire bit_sfr = is_bit && i_req.addr[7];
   wire [7:0] bit_byte = bit_sfr ? {i_req.addr[7:3], 3'h0}
                                 : RAM_BIT_BASE + {4'h0, i_req.addr[6:3]};
   wire [2:0] bit_idx = i_req.addr[2:0];
   wire [7:0] reg_byte = {3'h0, i_bank, i_req.addr[2:0]};
   wire [7:0] byte_addr = is_bit ? bit_byte
                        : (i_req.mode == AM_REGNUM) ? reg_byte : i_req.addr;
   // indirect reach of the upper half lands in ram, never in the special space
   wire to_special = ((i_req.mode == AM_DIRECT) && i_req.addr[7]) || bit_sfr;
   wire is_flreg = to_special && !is_bit && ((byte_addr == FL_ADDR_LO) ||
      (byte_addr == FL_ADDR_HI) || (byte_addr == FL_DATA) || (byte_addr == FL_CMD));
   wire to_sfr = to_special && !is_flreg;
   wire [7:0] fl_rd = (byte_addr == FL_ADDR_LO) ? fl_addr_r[7:0]
                    : (byte_addr == FL_ADDR_HI) ? {6'h0, fl_addr_r[9:8]}
                    : (byte_addr == FL_DATA) ? fl_data_r : 8'h00;
   wire [7:0] byte_rd = to_sfr ? i_sfr_rdata : is_flreg ? fl_rd : ram[byte_addr];
   wire [7:0] bit_mask = 8'h01 << bit_idx;
   wire [7:0] byte_wr = is_bit ? (i_req.wdata[0] ? (byte_rd | bit_mask) : (byte_rd & ~bit_mask))
                               : i_req.wdata;
   wire do_write = i_req.valid && i_req.write;
   wire fl_in_range = (fl_addr_r <= FLASH_LAST);
   wire fl_cmd_wr = do_write && is_flreg && (byte_addr == FL_CMD);

   assign o_sfr = '{i_req.valid && to_sfr, i_req.write, byte_addr, byte_wr};
   assign o_rdata = rdata_r;
   assign o_rvalid = rvalid_r;

   ////////////////////////////////////////////////////////////////////////////
   // storage
   always_ff @(posedge i_clock) begin
      if (do_write && !to_special) begin
         ram[byte_addr] <= byte_wr;
      end
      if (fl_cmd_wr && (i_req.wdata == FL_CMD_WRITE) && fl_in_range) begin
         flash[fl_addr_r] <= fl_data_r;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fl_addr_r <= 10'h000;
         fl_data_r <= 8'h00;
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= i_req.valid && !i_req.write;
         if (i_req.valid && !i_req.write) begin
            rdata_r <= is_bit ? {7'h00, byte_rd[bit_idx]} : byte_rd;
         end
         if (do_write && is_flreg && (byte_addr == FL_ADDR_LO)) begin
            fl_addr_r[7:0] <= i_req.wdata;
         end
         if (do_write && is_flreg && (byte_addr == FL_ADDR_HI)) begin
            fl_addr_r[9:8] <= i_req.wdata[1:0];
         end
         if (do_write && is_flreg && (byte_addr == FL_DATA)) begin
            fl_data_r <= i_req.wdata;
         end else if (fl_cmd_wr && (i_req.wdata == FL_CMD_READ) && fl_in_range) begin
            fl_data_r <= flash[fl_addr_r];
         end
      end
   end
endmodule : emb_idata_space

// [src/emb_bus_interface.sv]
// external program and data memory bus engine with internal data space
`timescale 1ns/100ps
module emb_bus_interface (
   input wire logic i_clock,
   input wire logic i_reset_n,
   // core side
   input emb_pkg::emb_fetch_t i_fetch,
   output logic o_fetch_ready,
   output logic o_fetch_done,
   output logic [7:0] o_fetch_data,
   input emb_pkg::emb_xdata_t i_xdata,
   output logic o_xdata_ready,
   output logic o_xdata_done,
   output logic [7:0] o_xdata_rdata,
   input wire logic i_port_wr,
   input wire logic [7:0] i_port_wdata,
   output logic [7:0] o_port_pins,
   output logic [12:0] o_prog_addr,
   input wire logic [7:0] i_prog_data,
   input emb_pkg::emb_idata_t i_idata,
   input wire logic [1:0] i_bank,
   output logic [7:0] o_idata_rdata,
   output logic o_idata_rvalid,
   output emb_pkg::emb_sfr_t o_sfr,
   input wire logic [7:0] i_sfr_rdata,
   output logic o_download_mode,
   // pins
   input wire logic i_external_fetch_select,
   output logic o_address_latch_strobe,
   input wire logic i_program_store_strobe,
   output logic o_program_store_strobe,
   output logic o_program_store_strobe_oe,
   input wire logic [7:0] i_low_address_data_port,
   output logic [7:0] o_low_address_data_port,
   output logic [7:0] o_low_address_data_port_oe,
   output logic [7:0] o_upper_address_port,
   output logic o_read_strobe_n,
   output logic o_write_strobe_n
);
   import emb_pkg::*;

   emb_state_t state_r, state_nxt;
   logic [2:0] phase_r;
   logic [1:0] strap_cnt_r;
   logic strap_done_r;
   logic download_r;
   logic ext_r;
   logic [15:0] faddr_r;
   logic xwrite_r;
   logic [23:0] xaddr_r;
   logic [7:0] xwdata_r;
   logic [7:0] latch_r;
   logic [7:0] fdata_r;
   logic [7:0] xrdata_r;
   logic fdone_r;
   logic xdone_r;
   logic ea_s1_r, ea_s2_r;
   logic ps_s1_r, ps_s2_r;
   logic [7:0] lad_s1_r, lad_s2_r;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ea_s1_r <= 1'b0;
         ea_s2_r <= 1'b0;
         ps_s1_r <= 1'b1;
         ps_s2_r <= 1'b1;
         lad_s1_r <= 8'h00;
         lad_s2_r <= 8'h00;
      end else begin
         ea_s1_r <= i_external_fetch_select;
         ea_s2_r <= ea_s1_r;
         ps_s1_r <= i_program_store_strobe;
         ps_s2_r <= ps_s1_r;
         lad_s1_r <= i_low_address_data_port;
         lad_s2_r <= lad_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slot sequencing
   wire running = strap_done_r && !download_r;
   wire slot_end = running && (phase_r == PH_LAST);
   wire take_x = slot_end && (state_r != ST_XADDR) && i_xdata.valid;
   wire take_f = slot_end && (state_r != ST_XADDR) && !i_xdata.valid && i_fetch.valid;
   // internal memory only at or below the top and only with the select high
   wire goes_ext = !ea_s2_r || (i_fetch.addr > INT_PROG_TOP);

   always_comb begin
      state_nxt = state_r;
      if (slot_end) begin
         unique case (state_r)
            ST_XADDR: state_nxt = ST_XSTROBE;
            ST_IDLE, ST_FETCH, ST_XSTROBE: begin
               state_nxt = take_x ? ST_XADDR : take_f ? ST_FETCH : ST_IDLE;
            end
         endcase
      end
   end

   assign o_xdata_ready = take_x;
   assign o_fetch_ready = take_f;

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= ST_IDLE;
         phase_r <= 3'h0;
      end else begin
         state_r <= state_nxt;
         if (running) begin
            phase_r <= slot_end ? 3'h0 : phase_r + 3'h1;
         end
      end
   end

   // strap sampled a few edges after release while the strobe is not driven
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         strap_cnt_r <= 2'h0;
         strap_done_r <= 1'b0;
         download_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_cnt_r <= strap_cnt_r + 2'h1;
         if (strap_cnt_r == STRAP_WAIT) begin
            strap_done_r <= 1'b1;
            download_r <= !ps_s2_r;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ext_r <= 1'b0;
         faddr_r <= 16'h0000;
         xwrite_r <= 1'b0;
         xaddr_r <= 24'h000000;
         xwdata_r <= 8'h00;
      end else begin
         if (take_f) begin
            faddr_r <= i_fetch.addr;
            ext_r <= goes_ext;
         end
         if (take_x) begin
            xaddr_r <= i_xdata.addr;
            xwrite_r <= i_xdata.write;
            xwdata_r <= i_xdata.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin decode
   wire ph_ale = (phase_r <= PH_ALE_END);
   wire ph_strobe = (phase_r >= PH_STROBE);
   wire st_fetch = (state_r == ST_FETCH);
   wire st_xaddr = (state_r == ST_XADDR);
   wire st_xstb = (state_r == ST_XSTROBE);
   wire ext_fetch = st_fetch && ext_r;
   wire ale_on = running && ph_ale && !st_xstb;
   wire program_store_strobe_on = running && ext_fetch && ph_strobe;
   wire wr_on = running && st_xstb && xwrite_r &&
                (phase_r >= PH_WR_FIRST) && (phase_r <= PH_WR_LAST);
   wire rd_on = running && st_xstb && !xwrite_r && (phase_r >= PH_WR_FIRST);
   // address leaves the port in the cycle the program strobe falls and memory starts to drive
   wire bus_addr = running && ((ext_fetch && !ph_strobe) || st_xaddr);
   wire bus_wdata = running && st_xstb && xwrite_r;
   wire [7:0] bus_value = bus_wdata ? xwdata_r : st_xaddr ? xaddr_r[7:0] : faddr_r[7:0];
   wire bus_mode = bus_addr || bus_wdata;

   assign o_address_latch_strobe = ale_on;
   assign o_program_store_strobe = !program_store_strobe_on;
   assign o_program_store_strobe_oe = strap_done_r && !download_r;
   assign o_read_strobe_n = !rd_on;
   assign o_write_strobe_n = !wr_on;
   // strong drive of both levels on the bus, open drain otherwise
   assign o_low_address_data_port = bus_mode ? bus_value : 8'h00;
   assign o_low_address_data_port_oe = bus_mode ? 8'hff : ~latch_r;
   assign o_upper_address_port = ext_fetch ? faddr_r[15:8]
                               : (st_xaddr && ph_ale) ? xaddr_r[23:16]
                               : xaddr_r[15:8];
   assign o_port_pins = lad_s2_r;
   assign o_prog_addr = faddr_r[12:0];

   ////////////////////////////////////////////////////////////////////////////
   // capture and completion
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         latch_r <= 8'hff;
         fdata_r <= 8'h00;
         xrdata_r <= 8'h00;
         fdone_r <= 1'b0;
         xdone_r <= 1'b0;
      end else begin
         fdone_r <= slot_end && st_fetch;
         xdone_r <= slot_end && st_xstb;
         if (i_port_wr) begin
            latch_r <= i_port_wdata;
         end
         if (slot_end && st_fetch) begin
            fdata_r <= ext_r ? lad_s2_r : i_prog_data;
         end
         if (slot_end && st_xstb && !xwrite_r) begin
            xrdata_r <= lad_s2_r;
         end
      end
   end

   assign o_fetch_done = fdone_r;
   assign o_fetch_data = fdata_r;
   assign o_xdata_done = xdone_r;
   assign o_xdata_rdata = xrdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // internal data space, apart from program space
   emb_idata_space u_idata (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_req(i_idata),
      .i_bank(i_bank),
      .o_rdata(o_idata_rdata),
      .o_rvalid(o_idata_rvalid),
      .o_sfr(o_sfr),
      .i_sfr_rdata(i_sfr_rdata)
   );

   assign o_download_mode = download_r;
endmodule : emb_bus_interface

// [testbench/emb_bus_interface_properties.sv]
// port assertions for the external memory bus interface
`timescale 1ns/100ps
module emb_bus_interface_properties (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input emb_pkg::emb_fetch_t i_fetch,
   input wire logic o_fetch_ready,
   input emb_pkg::emb_xdata_t i_xdata,
   input wire logic o_xdata_ready,
   input wire logic o_xdata_done,
   input wire logic o_download_mode,
   input wire logic i_external_fetch_select,
   input wire logic o_address_latch_strobe,
   input wire logic o_program_store_strobe,
   input wire logic o_program_store_strobe_oe,
   input wire logic [7:0] o_low_address_data_port,
   input wire logic [7:0] o_low_address_data_port_oe,
   input wire logic [7:0] o_upper_address_port,
   input wire logic o_read_strobe_n,
   input wire logic o_write_strobe_n
);
   import emb_pkg::*;
   logic [3:0] sel_r;
   logic ext_go;
   logic ale;
   logic pss;
   assign ale = o_address_latch_strobe;
   assign pss = o_program_store_strobe;
   // select history guards against the pin synchroniser delay
   assign ext_go = o_fetch_ready && (i_fetch.addr > INT_PROG_TOP ||
      (sel_r == 4'h0 && !i_external_fetch_select));
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) sel_r <= 4'h0;
      else sel_r <= {sel_r[2:0], i_external_fetch_select};
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   a_ale_width: assert property ($rose(ale) |=> ale ##1 !ale)
      else $error("address strobe width wrong");
   a_ale_period: assert property ($rose(ale) |->
      (##6 ale) or (##7 !(o_read_strobe_n && o_write_strobe_n)))
      else $error("address strobe slot missed");
   a_strobe_after_ale: assert property ($fell(pss) |-> !ale && $past(ale, 2) && !$past(ale))
      else $error("program strobe overlaps address strobe");
   a_strobe_width: assert property ($fell(pss) |-> !pss [*3] ##1 pss)
      else $error("program strobe width wrong");
   a_internal_quiet: assert property (o_fetch_ready && i_fetch.addr <= INT_PROG_TOP &&
      sel_r == 4'hf && i_external_fetch_select |=> pss [*6])
      else $error("program strobe active on internal fetch");
   a_external_fetch: assert property (ext_go |-> ##4 !pss && o_program_store_strobe_oe)
      else $error("external fetch without program strobe");
   a_fetch_addr_out: assert property (ext_go |=> ale && o_low_address_data_port_oe == 8'hff &&
      {o_upper_address_port, o_low_address_data_port} == $past(i_fetch.addr))
      else $error("fetch address not on ports");
   a_xdata_addr_out: assert property (o_xdata_ready |=> ale &&
      {o_upper_address_port, o_low_address_data_port} ==
      {$past(i_xdata.addr[23:16]), $past(i_xdata.addr[7:0])}
      ##3 o_upper_address_port == $past(i_xdata.addr[15:8], 4))
      else $error("data address bytes wrong");
   a_xdata_done_time: assert property (o_xdata_ready |-> ##13 o_xdata_done)
      else $error("data access did not finish in two slots");
   a_write_strobe: assert property ($fell(o_write_strobe_n) |->
      (!o_write_strobe_n && o_low_address_data_port_oe == 8'hff) [*4] ##1 o_write_strobe_n)
      else $error("write strobe shape wrong");
   a_read_strobe: assert property ($fell(o_read_strobe_n) |->
      (!o_read_strobe_n && o_low_address_data_port_oe == 8'h00) [*5] ##1 o_read_strobe_n)
      else $error("read strobe shape wrong");
   a_download_quiet: assert property (o_download_mode |-> !ale && !o_program_store_strobe_oe)
      else $error("bus active in download mode");
   c_ext_fetch: cover property (ext_go);
   c_xdata_write: cover property (o_xdata_ready && i_xdata.write);
   c_download: cover property (o_download_mode);
endmodule : emb_bus_interface_properties
bind emb_bus_interface emb_bus_interface_properties chk_u (.*);

// [testbench/emb_ext_memory.sv]
// external program and data memory behind an address latch
`timescale 1ns/100ps
module emb_ext_memory (
   input wire logic i_clock,
   input wire logic i_ale,
   input wire logic i_prog_strobe_n,
   input wire logic i_read_strobe_n,
   input wire logic i_write_strobe_n,
   input wire logic [7:0] i_low_port,
   input wire logic [7:0] i_upper_port,
   output logic [7:0] o_data,
   output logic o_drive
);
   logic [7:0] lo_r;
   logic [7:0] page_r;
   logic [7:0] mem [int];
   logic [23:0] xaddr;
   assign xaddr = {page_r, i_upper_port, lo_r};
   always @(posedge i_clock) begin
      if (i_ale) begin
         lo_r <= i_low_port;
         page_r <= i_upper_port;
      end
      if (!i_write_strobe_n) mem[xaddr] = i_low_port;
   end
   // drives only while a strobe is low; the bench shows released lines as unknown-like
   always @* begin
      o_drive = !i_prog_strobe_n || !i_read_strobe_n;
      if (!i_read_strobe_n) o_data = mem.exists(xaddr) ? mem[xaddr] : xaddr[7:0] ^ 8'ha5;
      else o_data = i_upper_port ^ lo_r ^ 8'h3c;
   end
endmodule : emb_ext_memory

// [testbench/external_memory_bus_interface_test.sv]
// self-checking bench for the external memory bus interface
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %0t got %h exp %h", $time, got, exp); end end
module external_memory_bus_interface_test;
   import emb_pkg::*;
   logic i_clock = 1'b0;
   logic i_reset_n = 1'b0;
   emb_fetch_t i_fetch = '0;
   emb_xdata_t i_xdata = '0;
   emb_idata_t i_idata = '0;
   logic i_port_wr = 1'b0;
   logic [7:0] i_port_wdata = 8'h00;
   logic [1:0] i_bank = 2'h0;
   logic i_external_fetch_select = 1'b1;
   logic strap = 1'b1;
   logic [7:0] last_r = 8'h00;
   int fails = 0;
   int comparisons = 0;
   int seed = 32'had801718;
   logic o_fetch_ready, o_fetch_done, o_xdata_ready, o_xdata_done, o_idata_rvalid;
   logic o_download_mode, o_address_latch_strobe, i_program_store_strobe, mem_en;
   logic o_program_store_strobe, o_program_store_strobe_oe, o_read_strobe_n, o_write_strobe_n;
   logic [7:0] o_fetch_data, o_xdata_rdata, o_port_pins, i_prog_data, o_idata_rdata, i_sfr_rdata;
   logic [7:0] i_low_address_data_port, o_low_address_data_port, o_low_address_data_port_oe;
   logic [7:0] o_upper_address_port, mem_d;
   logic [12:0] o_prog_addr;
   emb_sfr_t o_sfr;
   logic [7:0] dmem [int];
   always #2 i_clock = ~i_clock;
   assign i_program_store_strobe = o_program_store_strobe_oe ? o_program_store_strobe : strap;
   assign i_low_address_data_port = (o_low_address_data_port_oe & o_low_address_data_port) |
      (~o_low_address_data_port_oe & (mem_en ? mem_d : ~last_r));
   assign i_prog_data = ~o_prog_addr[7:0] ^ {3'h0, o_prog_addr[12:8]};
   assign i_sfr_rdata = o_sfr.addr ^ 8'h5a;
   always @(posedge i_clock) last_r <= i_low_address_data_port;
   emb_bus_interface dut_u (.*);
   emb_ext_memory mem_u (.i_clock(i_clock), .i_ale(o_address_latch_strobe),
      .i_prog_strobe_n(i_program_store_strobe), .i_read_strobe_n(o_read_strobe_n),
      .i_write_strobe_n(o_write_strobe_n), .i_low_port(i_low_address_data_port),
      .i_upper_port(o_upper_address_port), .o_data(mem_d), .o_drive(mem_en));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] pexp(input logic [15:0] a);
      if (a > 16'h1fff || !i_external_fetch_select) return a[15:8] ^ a[7:0] ^ 8'h3c;
      return ~a[7:0] ^ {3'h0, a[12:8]};
   endfunction : pexp
   function automatic logic [7:0] dexp(input logic [23:0] a);
      return dmem.exists(a) ? dmem[a] : a[7:0] ^ 8'ha5;
   endfunction : dexp
   task automatic print_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic fetch(input logic [15:0] a);
      int n = 0;
      @(posedge i_clock);
      i_fetch <= '{1'b1, a};
      @(negedge i_clock);
      while (o_fetch_ready !== 1'b1 && n < 40) begin @(negedge i_clock); n++; end
      @(posedge i_clock);
      i_fetch.valid <= 1'b0;
      while (o_fetch_done !== 1'b1 && n < 60) begin @(negedge i_clock); n++; end
      if (n >= 60) fails++;
      `CHK(o_fetch_data, pexp(a))
   endtask : fetch
   task automatic xfer(input logic w, input logic [23:0] a, input logic [7:0] d);
      int n = 0;
      @(posedge i_clock);
      i_xdata <= '{1'b1, w, a, d};
      if (w) dmem[a] = d;
      @(negedge i_clock);
      while (o_xdata_ready !== 1'b1 && n < 40) begin @(negedge i_clock); n++; end
      @(posedge i_clock);
      i_xdata.valid <= 1'b0;
      while (o_xdata_done !== 1'b1 && n < 60) begin @(negedge i_clock); n++; end
      if (n >= 60) fails++;
      if (!w) `CHK(o_xdata_rdata, dexp(a))
   endtask : xfer
   task automatic iacc(input logic w, input emb_amode_t m, input logic [7:0] a, d, e);
      @(posedge i_clock);
      i_idata <= '{1'b1, w, m, a, d};
      @(posedge i_clock);
      i_idata.valid <= 1'b0;
      @(negedge i_clock);
      if (!w) `CHK({o_idata_rvalid, o_idata_rdata}, {1'b1, e})
   endtask : iacc
   initial begin
      #40000;
      fails++;
      print_verdict();
   end
   initial begin
      logic [31:0] v;
      repeat (10) @(posedge i_clock);
      i_reset_n <= 1'b1;
      fetch(16'h1fff);
      fetch(16'h2000);
      @(posedge i_clock);
      i_external_fetch_select <= 1'b0;
      repeat (4) @(posedge i_clock);
      fetch(16'h0010);
      @(posedge i_clock);
      i_external_fetch_select <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         v = $random(seed);
         xfer(1'b1, v[23:0], v[31:24]);
         xfer(1'b0, v[23:0], 8'h00);
         xfer(1'b0, v[23:0] ^ 24'h010100, 8'h00);
         fetch(v[15:0]);
      end
      for (int b = 0; b < 4; b++) begin
         v = $random(seed);
         @(posedge i_clock);
         i_bank <= b[1:0];
         iacc(1'b1, AM_REGNUM, {5'h0, v[2:0]}, v[15:8], 8'h00);
         iacc(1'b0, AM_DIRECT, {3'h0, b[1:0], v[2:0]}, 8'h00, v[15:8]);
      end
      iacc(1'b1, AM_DIRECT, 8'h2f, 8'h00, 8'h00);
      iacc(1'b1, AM_BIT, 8'h7f, 8'h01, 8'h00);
      iacc(1'b0, AM_DIRECT, 8'h2f, 8'h00, 8'h80);
      iacc(1'b0, AM_BIT, 8'h7f, 8'h00, 8'h01);
      iacc(1'b1, AM_DIRECT, 8'h20, 8'hff, 8'h00);
      iacc(1'b1, AM_BIT, 8'h00, 8'h00, 8'h00);
      iacc(1'b0, AM_DIRECT, 8'h20, 8'h00, 8'hfe);
      iacc(1'b1, AM_INDIRECT, 8'h90, 8'h33, 8'h00);
      iacc(1'b0, AM_INDIRECT, 8'h90, 8'h00, 8'h33);
      iacc(1'b0, AM_DIRECT, 8'h90, 8'h00, 8'hca);
      iacc(1'b1, AM_DIRECT, FL_ADDR_LO, 8'h7f, 8'h00);
      iacc(1'b1, AM_DIRECT, FL_ADDR_HI, 8'h02, 8'h00);
      iacc(1'b1, AM_DIRECT, FL_DATA, 8'hc6, 8'h00);
      iacc(1'b1, AM_DIRECT, FL_CMD, FL_CMD_WRITE, 8'h00);
      iacc(1'b1, AM_DIRECT, FL_DATA, 8'h00, 8'h00);
      iacc(1'b1, AM_DIRECT, FL_CMD, FL_CMD_READ, 8'h00);
      iacc(1'b0, AM_DIRECT, FL_DATA, 8'h00, 8'hc6);
      iacc(1'b1, AM_DIRECT, FL_ADDR_HI, 8'h03, 8'h00);
      iacc(1'b1, AM_DIRECT, FL_CMD, FL_CMD_READ, 8'h00);
      iacc(1'b0, AM_DIRECT, FL_DATA, 8'h00, 8'hc6);
      i_reset_n <= 1'b0;
      strap <= 1'b0;
      repeat (10) @(posedge i_clock);
      i_reset_n <= 1'b1;
      repeat (20) @(posedge i_clock);
      i_port_wr <= 1'b1;
      i_port_wdata <= 8'h5a;
      @(posedge i_clock);
      i_port_wr <= 1'b0;
      repeat (2) @(negedge i_clock);
      `CHK({o_download_mode, o_address_latch_strobe}, 2'b10)
      `CHK(o_low_address_data_port_oe, 8'ha5)
      @(negedge i_clock);
      `CHK(o_port_pins & 8'ha5, 8'h00)
      print_verdict();
   end
endmodule : external_memory_bus_interface_test
